// ---- verilog/flash_seq_defines.vh ----
// Constants for the serial flash command sequencer
// What this block does
// - Status bit 3 reads high while a flash operation runs, clears itself.
// - A 16-bit reception puts its upper byte in the upper register.
// - An 8 or 16-bit reception puts its lower byte into the lower register.
// - Command opcode register, reset zero, is the opcode of raw commands.
// - Chip select bit 0 drives device zero select; bits 3..1 are storage.
// - Size field decodes 000/001/011 to 512k/1M/4M; 100 is ambiguous.
// - Operation bit 7 picks one of two continuous programming styles.
// - Operation bit 6 sends the raw command, self-clears on completion.
// - Operation bit 5 reads flash status, self-clears on completion.
// - Operation bit 4 writes flash status, self-clears on completion.
// - Operation bit 3 erases a sector, self-clears on completion.
// - Operation bit 2 reads identification, self-clears on completion.
// - Op bit 1 programs; software or memory cycle sets it; self-clears.
// - Op bit 0 reads data; software or memory cycle sets it; self-clears.
// - Erase, program and read address come from three byte registers.
// - Burst count register, reset zero, gives bytes for program when op bit 7 is zero.
// - Transmit byte register, reset zero, feeds program and status write.
// - Completion flag sets when a transfer ends; writing one clears it.
// - Idle level setting one idles clock high, zero idles clock low.
// - Phase setting one puts first edge at start, zero half a bit in.
// - Lsb-first setting one shifts lsb first, else msb first.
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
`define IDX_CTRL 8'hf0
`define IDX_STAT 8'hf3
`define IDX_RXHI 8'hf4
`define IDX_CMD 8'hf5
`define IDX_SEL 8'hf6
`define IDX_SIZE 8'hf7
`define IDX_OP 8'hf8
`define IDX_RXLO 8'hfa
`define IDX_ADH 8'hfb
`define IDX_ADM 8'hfc
`define IDX_ADL 8'hfd
`define IDX_CNT 8'hfe
`define IDX_TXB 8'hff
`define STAT_DONE_BIT 7
`define STAT_BUSY_BIT 3
`define OP_TYPE_BIT 7
`define CTRL_IDLE_BIT 3
`define CTRL_PHASE_BIT 2
`define CTRL_LSB_BIT 0
`define OPC_STATUS_READ_GO 8'h05
`define OPC_STATUS_WRITE_GO 8'h01
`define OPC_ERASE 8'h20
`define OPC_ID 8'h90
`define OPC_PROGRAM_GO 8'h02
`define OPC_AAI 8'had
`define OPC_READ 8'h03
`define MASK_512K 24'h07ffff
`define MASK_1M 24'h0fffff
`define MASK_2M 24'h1fffff
`define MASK_4M 24'h3fffff
`define MASK_8M 24'h7fffff
`endif

// ---- verilog/spi_flash_command_sequencer.v ----
// Register-driven serial flash command sequencer with a Wishbone slave
`include "flash_seq_defines.vh"
`default_nettype none
module spi_flash_command_sequencer #(
   parameter HALF_DIV = 4
) (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire mem_read_req_i,
   input wire mem_program_go_req_i,
   output reg op_done_o,
   output reg sck_o,
   output reg mosi_o,
   output reg select_device_zero_n_o,
   input wire miso_i
);

   localparam ST_IDLE = 2'b00;
   localparam ST_LOAD = 2'b01;
   localparam ST_SHIFT = 2'b10;
   localparam ST_DONE = 2'b11;
   localparam integer DIV_LAST_I = HALF_DIV - 1;
   localparam [7:0] DIV_LAST = DIV_LAST_I[7:0];
   localparam [2:0] BIT_LAST = 3'h7;

   reg [7:0] cmd_q;
   reg [3:0] sel_q;
   reg [2:0] size_q;
   reg type_q;
   reg [6:0] go_q;
   reg [7:0] rxh_q;
   reg [7:0] rxl_q;
   reg [7:0] adh_q;
   reg [7:0] adm_q;
   reg [7:0] adl_q;
   reg [7:0] burst_program_count_q;
   reg [7:0] txb_q;
   reg [2:0] ctl_q;
   reg done_q;
   reg [1:0] state_q;
   reg [6:0] run_q;
   reg [8:0] byte_q;
   reg [2:0] bit_q;
   reg half_q;
   reg [7:0] div_q;
   reg [7:0] sh_q;
   reg [7:0] rxsh_q;
   reg rx_first_q;
   reg miso_m_q;
   reg miso_s_q;

   wire clock_idle_level = ctl_q[2];
   wire clock_phase_select = ctl_q[1];
   wire lsb_first_select = ctl_q[0];
   // Busy covers load and done as well as the shifting itself
   wire transfer_in_progress = (state_q != ST_IDLE);
   wire [7:0] idx = wb_adr_i[9:2];
   wire wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   wire [7:0] wd = wb_dat_i[7:0];

   // Size field bounds the address so it wraps inside the part
   reg [23:0] size_mask;
   always @* begin
      case (size_q)
         3'h0: size_mask = `MASK_512K;
         3'h1: size_mask = `MASK_1M;
         3'h3: size_mask = `MASK_4M;
         // Code 100 is printed for two sizes; 2M is the cautious reading
         3'h4: size_mask = `MASK_2M;
         default: size_mask = `MASK_8M;
      endcase
   end

   wire [23:0] flash_addr = {adh_q, adm_q, adl_q} & size_mask;

   // Frame shape of the operation in progress
   reg [7:0] opc;
   reg has_addr;
   reg [8:0] ndat;
   reg [1:0] nrx;
   always @* begin
      opc = cmd_q;
      has_addr = 1'b0;
      ndat = 9'h000;
      nrx = 2'h0;
      if (run_q[6]) begin
         opc = cmd_q;
      end else if (run_q[5]) begin
         opc = `OPC_STATUS_READ_GO;
         nrx = 2'h1;
      end else if (run_q[4]) begin
         opc = `OPC_STATUS_WRITE_GO;
         ndat = 9'h001;
      end else if (run_q[3]) begin
         opc = `OPC_ERASE;
         has_addr = 1'b1;
      end else if (run_q[2]) begin
         opc = `OPC_ID;
         has_addr = 1'b1;
         nrx = 2'h2;
      end else if (run_q[1]) begin
         has_addr = 1'b1;
         if (type_q) begin
            opc = `OPC_AAI;
            ndat = 9'h001;
         end else begin
            opc = `OPC_PROGRAM_GO;
            if (burst_program_count_q == 8'h00)
               ndat = 9'h001;
            else
               ndat = {1'b0, burst_program_count_q};
         end
      end else if (run_q[0]) begin
         opc = `OPC_READ;
         has_addr = 1'b1;
         nrx = 2'h1;
      end
   end

   // Frame length in bytes: opcode, address, data, then reception
   wire [8:0] ntx = 9'h001 + (has_addr ? 9'h003 : 9'h000) + ndat;
   wire [8:0] nall = ntx + {7'h00, nrx};
   wire [8:0] byte_nx = byte_q + 9'h001;

   // Byte sent at position byte_nx; reception bytes send zeros
   reg [7:0] tx_next;
   always @* begin
      tx_next = 8'h00;
      if (byte_nx < ntx) begin
         if (has_addr && byte_nx == 9'h001)
            tx_next = flash_addr[23:16];
         else if (has_addr && byte_nx == 9'h002)
            tx_next = flash_addr[15:8];
         else if (has_addr && byte_nx == 9'h003)
            tx_next = flash_addr[7:0];
         else
            tx_next = txb_q;
      end
   end

   // Highest operation bit wins when software sets several at once
   reg [6:0] pick;
   always @* begin
      pick = 7'h00;
      if (go_q[6]) pick = 7'h40;
      else if (go_q[5]) pick = 7'h20;
      else if (go_q[4]) pick = 7'h10;
      else if (go_q[3]) pick = 7'h08;
      else if (go_q[2]) pick = 7'h04;
      else if (go_q[1]) pick = 7'h02;
      else if (go_q[0]) pick = 7'h01;
   end

   wire [7:0] rx_in = lsb_first_select ? {miso_s_q, rxsh_q[7:1]} :
      {rxsh_q[6:0], miso_s_q};
   wire [7:0] sh_adv = lsb_first_select ? {1'b0, sh_q[7:1]} :
      {sh_q[6:0], 1'b0};
   // One bit is two ticks: leading half, then trailing half
   wire tick = (div_q == DIV_LAST);
   wire finish = (state_q == ST_DONE);

   // Miso crosses from the pin through two flops
   always @(posedge clk_i) begin
      if (rst_i) begin
         miso_m_q <= 1'b0;
         miso_s_q <= 1'b0;
      end else if (ce_i) begin
         miso_m_q <= miso_i;
         miso_s_q <= miso_m_q;
      end
   end

   // Wishbone slave: ack one cycle after the strobe, data at the ack edge
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         // A strobe held across the ack is not answered twice
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= 32'h00000000;
         if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
            case (idx)
               `IDX_CTRL: wb_dat_o[7:0] <= {4'h0, clock_idle_level,
                  clock_phase_select, 1'b0, lsb_first_select};
               `IDX_STAT: wb_dat_o[7:0] <= {done_q, 3'h0,
                  transfer_in_progress, 3'h0};
               `IDX_RXHI: wb_dat_o[7:0] <= rxh_q;
               `IDX_CMD: wb_dat_o[7:0] <= cmd_q;
               `IDX_SEL: wb_dat_o[7:0] <= {4'h0, sel_q};
               `IDX_SIZE: wb_dat_o[7:0] <= {5'h00, size_q};
               `IDX_OP: wb_dat_o[7:0] <= {type_q, go_q};
               `IDX_RXLO: wb_dat_o[7:0] <= rxl_q;
               `IDX_ADH: wb_dat_o[7:0] <= adh_q;
               `IDX_ADM: wb_dat_o[7:0] <= adm_q;
               `IDX_ADL: wb_dat_o[7:0] <= adl_q;
               `IDX_CNT: wb_dat_o[7:0] <= burst_program_count_q;
               `IDX_TXB: wb_dat_o[7:0] <= txb_q;
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // Software-owned registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q <= 8'h00;
         sel_q <= 4'h0;
         size_q <= 3'h0;
         type_q <= 1'b0;
         adh_q <= 8'h00;
         adm_q <= 8'h00;
         adl_q <= 8'h00;
         burst_program_count_q <= 8'h00;
         txb_q <= 8'h00;
         ctl_q <= 3'h0;
      end else if (ce_i && wr_en) begin
         case (idx)
            `IDX_CTRL: ctl_q <= {wd[`CTRL_IDLE_BIT], wd[`CTRL_PHASE_BIT],
               wd[`CTRL_LSB_BIT]};
            `IDX_CMD: cmd_q <= wd;
            `IDX_SEL: sel_q <= wd[3:0];
            `IDX_SIZE: size_q <= wd[2:0];
            `IDX_OP: type_q <= wd[`OP_TYPE_BIT];
            `IDX_ADH: adh_q <= wd;
            `IDX_ADM: adm_q <= wd;
            `IDX_ADL: adl_q <= wd;
            `IDX_CNT: burst_program_count_q <= wd;
            `IDX_TXB: txb_q <= wd;
            default: ;
         endcase
      end
   end

   // Start bits: set by software or memory cycle; a set beats the clear
   wire [6:0] go_d;
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_go
         wire sw_set = wr_en && (idx == `IDX_OP) && wd[g];
         // Memory cycles can only start a program or a data read
         wire hw_set = (g == 1) ? mem_program_go_req_i :
            (g == 0) ? mem_read_req_i : 1'b0;
         wire clr = finish && run_q[g];
         assign go_d[g] = (sw_set || hw_set) ? 1'b1 : (clr ? 1'b0 : go_q[g]);
      end
   endgenerate

   always @(posedge clk_i) begin
      if (rst_i) begin
         go_q <= 7'h00;
      end else if (ce_i) begin
         go_q <= go_d;
      end
   end

   // Completion flag: write one clears, a new completion wins
   always @(posedge clk_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
      end else if (ce_i) begin
         if (finish)
            done_q <= 1'b1;
         else if (wr_en && idx == `IDX_STAT && wd[`STAT_DONE_BIT])
            done_q <= 1'b0;
      end
   end

   // Serial engine. Miso is read two cycles late through the
   // synchroniser, so HALF_DIV must stay above two.
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         run_q <= 7'h00;
         byte_q <= 9'h000;
         bit_q <= 3'h0;
         half_q <= 1'b0;
         div_q <= 8'h00;
         sh_q <= 8'h00;
         rxsh_q <= 8'h00;
         rx_first_q <= 1'b0;
         rxh_q <= 8'h00;
         rxl_q <= 8'h00;
         sck_o <= 1'b0;
         mosi_o <= 1'b0;
         select_device_zero_n_o <= 1'b1;
         op_done_o <= 1'b0;
      end else if (ce_i) begin
         op_done_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               sck_o <= clock_idle_level;
               select_device_zero_n_o <= 1'b1;
               if (pick != 7'h00) begin
                  run_q <= pick;
                  state_q <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               byte_q <= 9'h000;
               bit_q <= 3'h0;
               half_q <= 1'b0;
               div_q <= 8'h00;
               sh_q <= opc;
               rx_first_q <= 1'b1;
               mosi_o <= lsb_first_select ? opc[0] : opc[7];
               // Only bit 0 of the select register reaches the pin
               select_device_zero_n_o <= ~sel_q[0];
               // Phase one makes the leading edge right at the start
               sck_o <= clock_idle_level ^ clock_phase_select;
               state_q <= ST_SHIFT;
            end
            ST_SHIFT: begin
               div_q <= tick ? 8'h00 : div_q + 8'h01;
               if (tick && !half_q) begin
                  half_q <= 1'b1;
                  // Mid-bit sample, well after the far side's change
                  rxsh_q <= rx_in;
                  sck_o <= clock_idle_level ^ ~clock_phase_select;
               end else if (tick) begin
                  half_q <= 1'b0;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == BIT_LAST) begin
                     byte_q <= byte_nx;
                     if (byte_q >= ntx) begin
                        rx_first_q <= 1'b0;
                        if (nrx == 2'h2 && rx_first_q)
                           rxh_q <= rxsh_q;
                        else
                           rxl_q <= rxsh_q;
                     end
                     if (byte_nx == nall) begin
                        sck_o <= clock_idle_level;
                        state_q <= ST_DONE;
                     end else begin
                        sh_q <= tx_next;
                        mosi_o <= lsb_first_select ? tx_next[0] :
                           tx_next[7];
                        sck_o <= clock_idle_level ^ clock_phase_select;
                     end
                  end else begin
                     sh_q <= sh_adv;
                     mosi_o <= lsb_first_select ? sh_adv[0] : sh_adv[7];
                     sck_o <= clock_idle_level ^ clock_phase_select;
                  end
               end
            end
            ST_DONE: begin
               // Busy drops here together with the self-clear
               select_device_zero_n_o <= 1'b1;
               sck_o <= clock_idle_level;
               run_q <= 7'h00;
               op_done_o <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// ---- tb/flash_seq_monitor.sv ----
// Port-level assertions for the flash command sequencer
`default_nettype none
module flash_seq_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic op_done_o,
   input wire logic select_device_zero_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_sel_drop;
      $fell(select_device_zero_n_o);
   endsequence
   // Even one opcode byte takes eight bit periods
   sequence s_op_end;
      ##[60:1000] op_done_o;
   endsequence
   property p_ack_resp;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data idle");
   property p_dat_lane;
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
   endproperty
   a_dat_lane: assert property (p_dat_lane) else $error("data lane");
   property p_done_pulse;
      op_done_o |=> !op_done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done");
   property p_done_cs;
      op_done_o |=> select_device_zero_n_o;
   endproperty
   a_done_cs: assert property (p_done_cs) else $error("select kept");
   property p_sel_hold;
      s_sel_drop |=> !select_device_zero_n_o [*8];
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select short");
   property p_op_len;
      s_sel_drop |-> s_op_end;
   endproperty
   a_op_len: assert property (p_op_len) else $error("op length");
endmodule
bind spi_flash_command_sequencer flash_seq_monitor i_mon (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .op_done_o(op_done_o),
   .select_device_zero_n_o(select_device_zero_n_o)
);
`default_nettype wire

// ---- tb/spi_flash_model.sv ----
// Behavioural serial flash, samples on the rising serial clock edge
`default_nettype none
module spi_flash_model (
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic select_n_i,
   output logic miso_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] RSP = 16'ha55a;
   logic [7:0] rx_b [0:7];
   logic [7:0] sh = 8'h00;
   int k = 0;
   int hdr;
   initial miso_o = 1'b0;
   always @(negedge select_n_i) k = 0;
   // Released line never keeps its last level
   always @(posedge select_n_i) miso_o <= ~miso_o;
   always @(posedge sck_i) if (!select_n_i) begin
      sh = {sh[6:0], mosi_i};
      if (k % 8 == 7 && k < 64) rx_b[k / 8] = sh;
      k = k + 1;
   end
   // Answer starts after opcode, or opcode plus address
   always @(negedge sck_i) if (!select_n_i) begin
      hdr = (rx_b[0] == 8'h05) ? 8 : 32;
      if (k >= hdr && k < hdr + 16) miso_o <= RSP[15 - (k - hdr)];
      else miso_o <= ~miso_o;
   end
endmodule
`default_nettype wire

// ---- tb/spi_flash_command_sequencer_tb.sv ----
// Register-level bench for the flash command sequencer
`default_nettype none
module spi_flash_command_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat = 32'h00000000;
   logic mem_rd = 1'b0;
   logic mem_pg = 1'b0;
   logic [7:0] q;
   wire [31:0] rdat;
   wire ack, done, sck, mosi, sel_n, miso;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] ri [6] = '{8'hf0, 8'hf3, 8'hf5, 8'hf6, 8'hfe, 8'hff};
   logic [15:0] cfg [8] = '{16'hf601, 16'hf703, 16'hfb52, 16'hfc34,
      16'hfd56, 16'hfe02, 16'hff3c, 16'hf59f};
   always #2 clk_i = ~clk_i;
   // Eight cycles a half bit gives a 64 ns serial clock period
   spi_flash_command_sequencer #(.HALF_DIV(8)) i_spi_flash_command_sequencer (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .mem_read_req_i(mem_rd), .mem_program_go_req_i(mem_pg), .op_done_o(done),
      .sck_o(sck), .mosi_o(mosi), .select_device_zero_n_o(sel_n),
      .miso_i(miso));
   spi_flash_model i_spi_flash_model (.sck_i(sck), .mosi_i(mosi),
      .select_n_i(sel_n), .miso_o(miso));
   task automatic wrap_up();
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      dat <= {24'h000000, d};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat[7:0];
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
      input string n);
      bus(a, 1'b0, 8'h00);
      chk(n, e, q);
   endtask
   // Code 00 pulses a memory read, 01 a memory program; one op at a time.
   // The model clocks the r receive bytes too, so they add to its count.
   task automatic op(input logic [7:0] v, input int n, input logic [63:0] e,
      input int r);
      int i;
      if (v < 8'h02) begin
         mem_rd <= (v == 8'h00);
         mem_pg <= (v == 8'h01);
         @(posedge clk_i);
         mem_rd <= 1'b0;
         mem_pg <= 1'b0;
         // A second edge lets the engine leave idle before busy is read
         @(posedge clk_i);
      end else begin
         bus(8'hf8, 1'b1, v);
      end
      rd_chk(8'hf3, 8'h08, "busy");
      while (done !== 1'b1) @(posedge clk_i);
      @(posedge clk_i);
      for (i = 0; i < n; i++)
         chk("flash byte", e[8*(n-1-i) +: 8], i_spi_flash_model.rx_b[i]);
      chk("byte count", 8'(n + r), 8'(i_spi_flash_model.k / 8));
      bus(8'hf8, 1'b0, 8'h00);
      chk("op bits", 8'h00, q & 8'h7f);
      rd_chk(8'hf3, 8'h80, "done flag");
      bus(8'hf3, 1'b1, 8'h80);
      rd_chk(8'hf3, 8'h00, "flag clear");
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (ri[j])
         rd_chk(ri[j], 8'h00, "reset value");
      bus(8'h10, 1'b1, 8'hff);
      rd_chk(8'h10, 8'h00, "unmapped");
      foreach (cfg[j]) bus(cfg[j][15:8], 1'b1, cfg[j][7:0]);
      rd_chk(8'hf5, 8'h9f, "opcode reg");
      chk("select idle", 8'h01, {7'h00, sel_n});
      op(8'h40, 1, 64'h9f, 0);
      op(8'h20, 1, 64'h05, 1);
      rd_chk(8'hfa, 8'ha5, "rx lower");
      op(8'h10, 2, 64'h013c, 0);
      op(8'h08, 4, 64'h20123456, 0);
      op(8'h04, 4, 64'h90123456, 2);
      rd_chk(8'hf4, 8'ha5, "rx upper");
      rd_chk(8'hfa, 8'h5a, "rx lower");
      bus(8'hf4, 1'b1, 8'h00);
      rd_chk(8'hf4, 8'ha5, "read only");
      op(8'h02, 6, 64'h021234563c3c, 0);
      op(8'h82, 5, 64'had1234563c, 0);
      op(8'h01, 5, 64'had1234563c, 0);
      op(8'h00, 4, 64'h03123456, 1);
      rd_chk(8'hfa, 8'ha5, "rx lower");
      bus(8'hf0, 1'b1, 8'h01);
      bus(8'hf5, 1'b1, 8'h01);
      op(8'h40, 1, 64'h80, 0);
      bus(8'hf0, 1'b1, 8'h08);
      repeat (8) @(posedge clk_i);
      chk("clock idle", 8'h01, {7'h00, sck});
      // Idle high with the leading edge at the start of each bit
      bus(8'hf0, 1'b1, 8'h0c);
      op(8'h20, 1, 64'h05, 1);
      rd_chk(8'hfa, 8'ha5, "rx lower");
      chk("clock idle", 8'h01, {7'h00, sck});
      wrap_up();
   end
endmodule
`default_nettype wire
